//--- core/usdc_desc_lookup.v
// Combinational lookup of which string a descriptor index returns, and its length.
// Assumes lengths arrive straight from the configuration registers.
`timescale 1ns/1ps
`default_nettype none
`include "usdc_map.vh"

module usdc_desc_lookup
#(
    parameter [7:0] SERIAL_INDEX  = `USDC_IDX_SERIAL,
    parameter [7:0] MAKER_INDEX   = `USDC_IDX_MAKER,
    parameter [7:0] PRODUCT_INDEX = `USDC_IDX_PRODUCT,
    parameter [6:0] SERIAL_MAX    = `USDC_MAX_SERIAL,
    parameter [6:0] TEXT_MAX      = `USDC_MAX_TEXT
)
(
    // Query
    input  wire [7:0]  index,
    // Configuration
    input  wire [7:0]  languageLow,
    input  wire [7:0]  languageHigh,
    input  wire [5:0]  serialLength,
    input  wire [6:0]  makerLength,
    input  wire [6:0]  productLength,
    // Result
    output reg         found,
    output reg  [6:0]  length,
    output reg  [1:0]  source,
    output wire [15:0] langId
);

    // Lengths above the supported maximum are cut to it
    function [6:0] clampLen;
        input [6:0] value;
        input [6:0] limit;
        begin
            clampLen = (value > limit) ? limit : value;
        end
    endfunction

    assign langId = {languageHigh, languageLow};

    always @*
    begin
        found  = 1'b0;
        length = 7'h00;
        source = `USDC_SRC_NONE;
        if (index == `USDC_IDX_LANG)
        begin
            // Table holds a single language code
            found  = 1'b1;
            length = `USDC_LANG_TABLE_LEN;
        end
        else if (index == SERIAL_INDEX && serialLength != 6'h00)
        begin
            found  = 1'b1;
            length = clampLen({1'b0, serialLength}, SERIAL_MAX);
            source = `USDC_SRC_SERIAL;
        end
        else if (index == MAKER_INDEX && makerLength != 7'h00)
        begin
            found  = 1'b1;
            length = clampLen(makerLength, TEXT_MAX);
            source = `USDC_SRC_MAKER;
        end
        else if (index == PRODUCT_INDEX && productLength != 7'h00)
        begin
            found  = 1'b1;
            length = clampLen(productLength, TEXT_MAX);
            source = `USDC_SRC_PRODUCT;
        end
    end

endmodule // usdc_desc_lookup

`default_nettype wire

//--- core/usdc_guard_reg.v
// One byte-wide configuration register whose write is gated by an unlock bit.
// Assumes a single synchronous write strobe from the configuration port.
`timescale 1ns/1ps
`default_nettype none

module usdc_guard_reg
#(
    parameter [7:0] RESET_VALUE = 8'h00,
    parameter [7:0] FIELD_MASK  = 8'hff
)
(
    // Clock and reset
    input  wire       clk,
    input  wire       reset_n,
    // Write side
    input  wire       writeEnable,
    input  wire       unlock,
    input  wire [7:0] writeData,
    // Stored value
    output wire [7:0] fieldValue
);

    reg  [7:0] field_r;
    wire [7:0] field_nxt;

    // ============================================================
    // Guarded update
    assign field_nxt = (writeEnable && unlock) ? (writeData & FIELD_MASK) : field_r;

    always @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            field_r <= RESET_VALUE & FIELD_MASK;
        else
            field_r <= field_nxt;
    end

    // Reserved bits never stored, so they read as zero
    assign fieldValue = field_r & FIELD_MASK;

endmodule // usdc_guard_reg

`default_nettype wire

//--- core/usdc_map.vh
// Offsets, field layouts, reset values and limits of the string descriptor
// configuration registers. Definitions only; included by its bare name.
`ifndef USDC_MAP_VH
`define USDC_MAP_VH

// ============================================================
// Register offsets (byte addresses on the configuration port)
`define USDC_OFS_LANG_LOW     8'h20
`define USDC_OFS_LANG_HIGH    8'h21
`define USDC_OFS_SERIAL_LEN   8'h22
`define USDC_OFS_MAKER_LEN    8'h23
`define USDC_OFS_PRODUCT_LEN  8'h24

// ============================================================
// Reset values
`define USDC_RST_LANG_LOW     8'h09
`define USDC_RST_LANG_HIGH    8'h04
`define USDC_RST_SERIAL_LEN   8'h18
`define USDC_RST_MAKER_LEN    8'h00
`define USDC_RST_PRODUCT_LEN  8'h00

// ============================================================
// Writable bits of each register
`define USDC_MASK_LANG        8'hff
`define USDC_MASK_SERIAL_LEN  8'h3f
`define USDC_MASK_TEXT_LEN    8'h7f

// ============================================================
// Descriptor indices and length limits
`define USDC_IDX_LANG         8'h00
`define USDC_IDX_SERIAL       8'h01
`define USDC_IDX_MAKER        8'h03
`define USDC_IDX_PRODUCT      8'h03
`define USDC_MAX_SERIAL       7'h20
`define USDC_MAX_TEXT         7'h40
`define USDC_LANG_TABLE_LEN   7'h02

// ============================================================
// Descriptor data source codes
`define USDC_SRC_NONE         2'h0
`define USDC_SRC_SERIAL       2'h1
`define USDC_SRC_MAKER        2'h2
`define USDC_SRC_PRODUCT      2'h3

`endif

//--- core/usdc_string_config.v
// String descriptor configuration registers of a hub with a descriptor query port.
// Assumes EEPROM loader and SMBus slave are merged onto one byte-wide register port
// upstream, and that the two custom enable bits come from elsewhere in the hub.
//
// Summary of operation
// - Low language byte is code LSB, 09h.
// - High language byte is code MSB, 04h.
// - Exactly one language code, default 0409h.
// - Language and text lengths writable only when unlocked.
// - Serial length in bits 5:0, reset 18h.
// - Serial strings limited to 32 bytes.
// - Serial length writable only when serial unlocked.
// - Nonzero serial length returns string index 1.
// - Maker length bits 6:0, zero means none.
// - Maker and product strings limited to 64.
// - Nonzero maker length returns string index 3.
// - Product length bits 6:0, zero means none.
// - Nonzero product length returns string index 3 while maker length is zero.
// - Reserved length bits read as zero.
`timescale 1ns/1ps
`default_nettype none
`include "usdc_map.vh"

module usdc_string_config
#(
    parameter [7:0] SERIAL_INDEX  = `USDC_IDX_SERIAL,
    parameter [7:0] MAKER_INDEX   = `USDC_IDX_MAKER,
    parameter [7:0] PRODUCT_INDEX = `USDC_IDX_PRODUCT
)
(
    // Clock and reset
    input  wire        clk,
    input  wire        reset_n,

    // Unlock controls
    input  wire        customTextEnable,
    input  wire        customSerialEnable,

    // Register port
    input  wire [7:0]  regAddr,
    input  wire        regWrite,
    input  wire [7:0]  regWriteData,
    input  wire        regRead,
    output wire [7:0]  regReadData,
    output wire        regReadValid,
    output wire        regReadHit,
    output wire        regWriteTaken,
    output wire        regWriteRefused,

    // Descriptor query
    input  wire        descRequest,
    input  wire [7:0]  descIndex,
    output wire        descValid,
    output wire        descFound,
    output wire [6:0]  descLength,
    output wire [1:0]  descSource,
    output wire [15:0] descLangId,

    // Current configuration
    output wire [15:0] languageId,
    output wire [5:0]  serialLength,
    output wire [6:0]  makerLength,
    output wire [6:0]  productLength
);

    // ============================================================
    // Register slots
    localparam [2:0] SLOT_NONE    = 3'h0;
    localparam [2:0] SLOT_LANG_LO = 3'h1;
    localparam [2:0] SLOT_LANG_HI = 3'h2;
    localparam [2:0] SLOT_SERIAL  = 3'h3;
    localparam [2:0] SLOT_MAKER   = 3'h4;
    localparam [2:0] SLOT_PRODUCT = 3'h5;

    function [2:0] regDecode;
        input [7:0] addr;
        begin
            if (addr == `USDC_OFS_LANG_LOW)
                regDecode = SLOT_LANG_LO;
            else if (addr == `USDC_OFS_LANG_HIGH)
                regDecode = SLOT_LANG_HI;
            else if (addr == `USDC_OFS_SERIAL_LEN)
                regDecode = SLOT_SERIAL;
            else if (addr == `USDC_OFS_MAKER_LEN)
                regDecode = SLOT_MAKER;
            else if (addr == `USDC_OFS_PRODUCT_LEN)
                regDecode = SLOT_PRODUCT;
            else
                regDecode = SLOT_NONE;
        end
    endfunction

    // ============================================================
    // Declarations
    wire [2:0]  writeSlot;
    wire [2:0]  readSlot;
    wire        slotUnlocked;
    wire [7:0]  langLowValue;
    wire [7:0]  langHighValue;
    wire [7:0]  serialValue;
    wire [7:0]  makerValue;
    wire [7:0]  productValue;
    wire        lookFound;
    wire [6:0]  lookLength;
    wire [1:0]  lookSource;
    wire [15:0] lookLangId;
    reg  [7:0]  readMux;

    reg  [7:0]  readData_r;
    reg         readValid_r;
    reg         readHit_r;
    reg         writeTaken_r;
    reg         writeRefused_r;
    reg         descValid_r;
    reg         descFound_r;
    reg  [6:0]  descLength_r;
    reg  [1:0]  descSource_r;
    reg  [15:0] descLangId_r;

    assign writeSlot = regDecode(regAddr);
    assign readSlot  = regDecode(regAddr);

    // ============================================================
    // Write gating
    // Serial length follows its own enable; the other four follow the text enable
    assign slotUnlocked = (writeSlot == SLOT_SERIAL) ? customSerialEnable :
                          (writeSlot != SLOT_NONE) ? customTextEnable : 1'b0;

    // ============================================================
    // Storage
    usdc_guard_reg
    #(
        .RESET_VALUE (`USDC_RST_LANG_LOW),
        .FIELD_MASK  (`USDC_MASK_LANG)
    )
    u_lang_low
    (
        .clk         (clk),
        .reset_n     (reset_n),
        .writeEnable (regWrite && writeSlot == SLOT_LANG_LO),
        .unlock      (customTextEnable),
        .writeData   (regWriteData),
        .fieldValue  (langLowValue)
    );

    usdc_guard_reg
    #(
        .RESET_VALUE (`USDC_RST_LANG_HIGH),
        .FIELD_MASK  (`USDC_MASK_LANG)
    )
    u_lang_high
    (
        .clk         (clk),
        .reset_n     (reset_n),
        .writeEnable (regWrite && writeSlot == SLOT_LANG_HI),
        .unlock      (customTextEnable),
        .writeData   (regWriteData),
        .fieldValue  (langHighValue)
    );

    usdc_guard_reg
    #(
        .RESET_VALUE (`USDC_RST_SERIAL_LEN),
        .FIELD_MASK  (`USDC_MASK_SERIAL_LEN)
    )
    u_serial_len
    (
        .clk         (clk),
        .reset_n     (reset_n),
        .writeEnable (regWrite && writeSlot == SLOT_SERIAL),
        .unlock      (customSerialEnable),
        .writeData   (regWriteData),
        .fieldValue  (serialValue)
    );

    usdc_guard_reg
    #(
        .RESET_VALUE (`USDC_RST_MAKER_LEN),
        .FIELD_MASK  (`USDC_MASK_TEXT_LEN)
    )
    u_maker_len
    (
        .clk         (clk),
        .reset_n     (reset_n),
        .writeEnable (regWrite && writeSlot == SLOT_MAKER),
        .unlock      (customTextEnable),
        .writeData   (regWriteData),
        .fieldValue  (makerValue)
    );

    usdc_guard_reg
    #(
        .RESET_VALUE (`USDC_RST_PRODUCT_LEN),
        .FIELD_MASK  (`USDC_MASK_TEXT_LEN)
    )
    u_product_len
    (
        .clk         (clk),
        .reset_n     (reset_n),
        .writeEnable (regWrite && writeSlot == SLOT_PRODUCT),
        .unlock      (customTextEnable),
        .writeData   (regWriteData),
        .fieldValue  (productValue)
    );

    // ============================================================
    // Read path
    always @*
    begin
        readMux = 8'h00;
        if (readSlot == SLOT_LANG_LO)
            readMux = langLowValue;
        else if (readSlot == SLOT_LANG_HI)
            readMux = langHighValue;
        else if (readSlot == SLOT_SERIAL)
            readMux = serialValue & `USDC_MASK_SERIAL_LEN;
        else if (readSlot == SLOT_MAKER)
            readMux = makerValue & `USDC_MASK_TEXT_LEN;
        else if (readSlot == SLOT_PRODUCT)
            readMux = productValue & `USDC_MASK_TEXT_LEN;
    end

    always @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            readData_r  <= 8'h00;
            readValid_r <= 1'b0;
            readHit_r   <= 1'b0;
        end
        else
        begin
            readValid_r <= regRead;
            if (regRead)
            begin
                readData_r <= readMux;
                readHit_r  <= (readSlot != SLOT_NONE);
            end
        end
    end

    // ============================================================
    // Write outcome
    always @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            writeTaken_r   <= 1'b0;
            writeRefused_r <= 1'b0;
        end
        else
        begin
            writeTaken_r   <= regWrite && slotUnlocked;
            writeRefused_r <= regWrite && !slotUnlocked;
        end
    end

    // ============================================================
    // Descriptor query
    usdc_desc_lookup
    #(
        .SERIAL_INDEX  (SERIAL_INDEX),
        .MAKER_INDEX   (MAKER_INDEX),
        .PRODUCT_INDEX (PRODUCT_INDEX),
        .SERIAL_MAX    (`USDC_MAX_SERIAL),
        .TEXT_MAX      (`USDC_MAX_TEXT)
    )
    u_lookup
    (
        .index         (descIndex),
        .languageLow   (langLowValue),
        .languageHigh  (langHighValue),
        .serialLength  (serialValue[5:0]),
        .makerLength   (makerValue[6:0]),
        .productLength (productValue[6:0]),
        .found         (lookFound),
        .length        (lookLength),
        .source        (lookSource),
        .langId        (lookLangId)
    );

    always @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            descValid_r  <= 1'b0;
            descFound_r  <= 1'b0;
            descLength_r <= 7'h00;
            descSource_r <= `USDC_SRC_NONE;
            descLangId_r <= 16'h0000;
        end
        else
        begin
            descValid_r <= descRequest;
            if (descRequest)
            begin
                descFound_r  <= lookFound;
                descLength_r <= lookLength;
                descSource_r <= lookSource;
                descLangId_r <= lookLangId;
            end
        end
    end

    // ============================================================
    // Outputs
    assign regReadData     = readData_r;
    assign regReadValid    = readValid_r;
    assign regReadHit      = readHit_r;
    assign regWriteTaken   = writeTaken_r;
    assign regWriteRefused = writeRefused_r;
    assign descValid       = descValid_r;
    assign descFound       = descFound_r;
    assign descLength      = descLength_r;
    assign descSource      = descSource_r;
    assign descLangId      = descLangId_r;
    assign languageId      = {langHighValue, langLowValue};
    assign serialLength    = serialValue[5:0];
    assign makerLength     = makerValue[6:0];
    assign productLength   = productValue[6:0];

endmodule // usdc_string_config

`default_nettype wire

//--- tb/usdc_host_model.sv
// Configuring host on the byte-wide register port.
// Assumes the bench calls wr and rd one at a time.
`timescale 1ns/1ps
`default_nettype none

module usdc_host_model
(
    // Clock
    input wire logic       clk,
    // Register port
    output var logic [7:0] regAddr,
    output var logic       regWrite,
    output var logic [7:0] regWriteData,
    output var logic       regRead,
    input wire logic [7:0] regReadData,
    input wire logic       regReadHit,
    input wire logic       regWriteTaken,
    input wire logic       regWriteRefused
);
    initial
    begin
        regAddr = 8'h00;
        regWrite = 1'b0;
        regWriteData = 8'h00;
        regRead = 1'b0;
    end

    // Write one byte; the unlock state decides whether it lands
    task automatic wr(input logic [7:0] a, input logic [7:0] d, output logic tk, output logic rf);
        @(posedge clk);
        regAddr <= a;
        regWriteData <= d;
        regWrite <= 1'b1;
        @(posedge clk);
        regWrite <= 1'b0;
        #1;
        tk = regWriteTaken;
        rf = regWriteRefused;
    endtask

    task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic hit);
        @(posedge clk);
        regAddr <= a;
        regRead <= 1'b1;
        @(posedge clk);
        regRead <= 1'b0;
        #1;
        d = regReadData;
        hit = regReadHit;
    endtask
endmodule // usdc_host_model

`default_nettype wire

//--- tb/usdc_string_config_bench.sv
// Self-checking bench of the string descriptor configuration registers.
// Assumes usdc_string_config, its checker and the host model.
`timescale 1ns/1ps
`default_nettype none

module usdc_string_config_bench;
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    logic customTextEnable = 1'b0;
    logic customSerialEnable = 1'b0;
    logic descRequest = 1'b0;
    logic [7:0] descIndex = 8'h00;
    wire logic [7:0] regAddr, regWriteData, regReadData;
    wire logic regWrite, regRead, regReadValid, regReadHit, regWriteTaken, regWriteRefused;
    wire logic descValid, descFound;
    wire logic [6:0] descLength, makerLength, productLength;
    wire logic [1:0] descSource;
    wire logic [15:0] descLangId, languageId;
    wire logic [5:0] serialLength;
    int miscompares = 0;
    int compares = 0;

    always #12.5 clk = ~clk;

    usdc_string_config usdc_string_config_i (.clk, .reset_n, .customTextEnable, .customSerialEnable,
        .regAddr, .regWrite, .regWriteData, .regRead, .regReadData, .regReadValid, .regReadHit,
        .regWriteTaken, .regWriteRefused, .descRequest, .descIndex, .descValid, .descFound,
        .descLength, .descSource, .descLangId, .languageId, .serialLength, .makerLength, .productLength);
    usdc_host_model usdc_host_model_i (.clk, .regAddr, .regWrite, .regWriteData, .regRead,
        .regReadData, .regReadHit, .regWriteTaken, .regWriteRefused);

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic wrchk(input logic [7:0] a, input logic [7:0] d, input logic tk);
        logic t, r;
        usdc_host_model_i.wr(a, d, t, r);
        chk({t, r}, {tk, ~tk});
    endtask

    task automatic rdchk(input logic [7:0] a, input logic [7:0] exp, input logic hit);
        logic [7:0] d;
        logic h;
        usdc_host_model_i.rd(a, d, h);
        chk({h, d}, {hit, exp});
    endtask

    task automatic query(input logic [7:0] idx, input logic f, input logic [6:0] len, input logic [1:0] src);
        @(posedge clk);
        descIndex <= idx;
        descRequest <= 1'b1;
        @(posedge clk);
        descRequest <= 1'b0;
        #1;
        chk({descValid, descFound, descLength, descSource}, {1'b1, f, len, src});
    endtask

    // ============================================================
    // Scenarios
    task automatic t_reset();
        @(posedge clk);
        reset_n <= 1'b0;
        customTextEnable <= 1'b0;
        customSerialEnable <= 1'b0;
        repeat (5) @(posedge clk);
        reset_n <= 1'b1;
        rdchk(8'h20, 8'h09, 1'b1);
        rdchk(8'h21, 8'h04, 1'b1);
        rdchk(8'h22, 8'h18, 1'b1);
        rdchk(8'h23, 8'h00, 1'b1);
        rdchk(8'h24, 8'h00, 1'b1);
        rdchk(8'h25, 8'h00, 1'b0);
        chk(languageId, 16'h0409);
        $display("Test reset values done");
    endtask

    task automatic t_locked();
        wrchk(8'h20, 8'haa, 1'b0);
        wrchk(8'h21, 8'hbb, 1'b0);
        wrchk(8'h23, 8'h11, 1'b0);
        wrchk(8'h24, 8'h22, 1'b0);
        wrchk(8'h22, 8'h05, 1'b0);
        @(posedge clk);
        customSerialEnable <= 1'b1;
        wrchk(8'h23, 8'h11, 1'b0);
        @(posedge clk);
        customSerialEnable <= 1'b0;
        customTextEnable <= 1'b1;
        wrchk(8'h22, 8'h05, 1'b0);
        chk(languageId, 16'h0409);
        chk(serialLength, 6'h18);
        chk({makerLength, productLength}, 14'h0000);
        $display("Test locked writes done");
    endtask

    task automatic t_write();
        @(posedge clk);
        customSerialEnable <= 1'b1;
        wrchk(8'h20, 8'h07, 1'b1);
        wrchk(8'h21, 8'h08, 1'b1);
        chk(languageId, 16'h0807);
        wrchk(8'h22, 8'hff, 1'b1);
        rdchk(8'h22, 8'h3f, 1'b1);
        wrchk(8'h23, 8'h85, 1'b1);
        rdchk(8'h23, 8'h05, 1'b1);
        wrchk(8'h24, 8'hc0, 1'b1);
        rdchk(8'h24, 8'h40, 1'b1);
        $display("Test unlocked writes done");
    endtask

    task automatic t_desc();
        query(8'h00, 1'b1, 7'h02, 2'h0);
        chk(descLangId, 16'h0807);
        query(8'h01, 1'b1, 7'h20, 2'h1);
        query(8'h03, 1'b1, 7'h05, 2'h2);
        wrchk(8'h23, 8'h00, 1'b1);
        query(8'h03, 1'b1, 7'h40, 2'h3);
        wrchk(8'h24, 8'h7f, 1'b1);
        query(8'h03, 1'b1, 7'h40, 2'h3);
        wrchk(8'h24, 8'h00, 1'b1);
        query(8'h03, 1'b0, 7'h00, 2'h0);
        wrchk(8'h22, 8'h00, 1'b1);
        query(8'h01, 1'b0, 7'h00, 2'h0);
        wrchk(8'h22, 8'h18, 1'b1);
        query(8'h01, 1'b1, 7'h18, 2'h1);
        query(8'h02, 1'b0, 7'h00, 2'h0);
        $display("Test descriptor queries done");
    endtask

    task automatic end_sim();
        $display("Comparisons %0d, mismatches %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    initial
    begin
        repeat (5000) @(posedge clk);
        miscompares++;
        end_sim();
    end

    initial
    begin
        t_reset();
        t_locked();
        t_write();
        t_desc();
        t_reset();
        end_sim();
    end
endmodule // usdc_string_config_bench

`default_nettype wire

//--- tb/usdc_string_config_monitor.sv
// Checker of the string descriptor configuration registers.
// Assumes binding to usdc_string_config; sees only its ports.
`timescale 1ns/1ps
`default_nettype none

module usdc_string_config_monitor
(
    // Clock and reset
    input wire logic        clk,
    input wire logic        reset_n,
    // Unlock controls
    input wire logic        customTextEnable,
    input wire logic        customSerialEnable,
    // Register port
    input wire logic [7:0]  regAddr,
    input wire logic        regWrite,
    input wire logic [7:0]  regWriteData,
    input wire logic        regRead,
    input wire logic [7:0]  regReadData,
    input wire logic        regReadValid,
    input wire logic        regWriteRefused,
    input wire logic        regWriteTaken,
    // Descriptor query
    input wire logic        descRequest,
    input wire logic [7:0]  descIndex,
    input wire logic        descValid,
    input wire logic        descFound,
    input wire logic [6:0]  descLength,
    input wire logic [1:0]  descSource,
    input wire logic [15:0] descLangId,
    // Configuration
    input wire logic [15:0] languageId,
    input wire logic [5:0]  serialLength,
    input wire logic [6:0]  makerLength,
    input wire logic [6:0]  productLength
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);

    wire logic textAddr = (regAddr == 8'h20) || (regAddr == 8'h21) || (regAddr == 8'h23) || (regAddr == 8'h24);

    reset_values_a: assert property ($rose(reset_n) |-> languageId == 16'h0409 && serialLength == 6'h18
        && makerLength == 7'h00 && productLength == 7'h00) else $error("Reset values wrong");
    text_lock_a: assert property (regWrite && textAddr && !customTextEnable
        |=> regWriteRefused && $stable(languageId) && $stable(makerLength) && $stable(productLength))
        else $error("Locked text write changed a field");
    serial_lock_a: assert property (regWrite && regAddr == 8'h22 && !customSerialEnable
        |=> regWriteRefused && $stable(serialLength)) else $error("Locked serial write changed length");
    serial_write_a: assert property (regWrite && regAddr == 8'h22 && customSerialEnable
        |=> regWriteTaken && serialLength == $past(regWriteData[5:0])) else $error("Serial write lost");
    maker_write_a: assert property (regWrite && regAddr == 8'h23 && customTextEnable
        |=> regWriteTaken && makerLength == $past(regWriteData[6:0])) else $error("Maker write lost");
    serial_read_a: assert property (regRead && regAddr == 8'h22
        |=> regReadValid && regReadData == {2'h0, $past(serialLength)}) else $error("Serial read wrong");
    product_read_a: assert property (regRead && regAddr == 8'h24
        |=> regReadValid && regReadData == {1'h0, $past(productLength)}) else $error("Product read wrong");
    lang_desc_a: assert property (descRequest && descIndex == 8'h00 |=> descValid && descFound
        && descLength == 7'h02 && descLangId == $past(languageId)) else $error("Language descriptor wrong");
    serial_desc_a: assert property (descRequest && descIndex == 8'h01 && serialLength != 6'h00
        |=> descFound && descSource == 2'h1
        && descLength == ($past(serialLength) > 6'h20 ? 7'h20 : {1'h0, $past(serialLength)}))
        else $error("Serial descriptor wrong");
    maker_desc_a: assert property (descRequest && descIndex == 8'h03 && makerLength != 7'h00
        |=> descFound && descSource == 2'h2
        && descLength == ($past(makerLength) > 7'h40 ? 7'h40 : $past(makerLength)))
        else $error("Maker descriptor wrong");
    product_desc_a: assert property (descRequest && descIndex == 8'h03 && makerLength == 7'h00
        && productLength != 7'h00 |=> descFound && descSource == 2'h3
        && descLength == ($past(productLength) > 7'h40 ? 7'h40 : $past(productLength)))
        else $error("Product descriptor wrong");
    no_string_a: assert property (descRequest && descIndex == 8'h03 && makerLength == 7'h00
        && productLength == 7'h00 |=> !descFound && descLength == 7'h00) else $error("Empty string found");
endmodule // usdc_string_config_monitor

bind usdc_string_config usdc_string_config_monitor usdc_string_config_monitor_i
(
    .clk, .reset_n, .customTextEnable, .customSerialEnable, .regAddr, .regWrite, .regWriteData,
    .regRead, .regReadData, .regReadValid, .regWriteRefused, .regWriteTaken, .descRequest, .descIndex,
    .descValid, .descFound, .descLength, .descSource, .descLangId, .languageId, .serialLength,
    .makerLength, .productLength
);

`default_nettype wire
